// ==== core/sss_consts.vh ====
// Constants for the status summary reporting block.
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// Command codes on the command port.
`define SSS_OP_RD_STB   4'h0
`define SSS_OP_RD_SRE   4'h1
`define SSS_OP_WR_SRE   4'h2
`define SSS_OP_RD_ESR   4'h3
`define SSS_OP_RD_ESE   4'h4
`define SSS_OP_WR_ESE   4'h5
`define SSS_OP_RD_ISCR0 4'h6
`define SSS_OP_RD_ISCR1 4'h7
`define SSS_OP_RD_ISCE0 4'h8
`define SSS_OP_WR_ISCE0 4'h9
`define SSS_OP_RD_ISCE1 4'ha
`define SSS_OP_WR_ISCE1 4'hb
`define SSS_OP_CLS      4'hc
`define SSS_OP_RST      4'hd
`define SSS_OP_RD_ERR   4'he

// Summary byte bit positions.
`define SSS_STB_MSS  6
`define SSS_STB_ESB  5
`define SSS_STB_MAV  4
`define SSS_STB_EAV  3
`define SSS_STB_INSTRUMENT_CHANGE_SUMMARY_FLAG 2
// Bits of the summary byte and service request mask that exist.
`define SSS_STB_USED 8'h7c

// Event latch word bit positions.
`define SSS_ESR_PON 7
`define SSS_ESR_CME 5
`define SSS_ESR_EXE 4
`define SSS_ESR_DDE 3
`define SSS_ESR_QYE 2
`define SSS_ESR_OPC 0
// Bits of the event latch word that exist.
`define SSS_ESR_USED 8'hbd

// Reset values.
`define SSS_RST_STB  8'h00
`define SSS_RST_SRE  8'h00
`define SSS_RST_ESR  8'h00
`define SSS_RST_ESE  8'h00
`define SSS_RST_ISC  16'h0000

// Error code pushed for an unknown command code.
`define SSS_ERR_BAD_CMD 8'h01
// Control-P character on the serial link.
`define SSS_CHAR_CTRL_P 8'h10

`endif

// ==== core/sss_error_queue.v ====
// Sixteen entry error code queue built from flip-flops.
module sss_error_queue #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             sys_rst,
  // Push side
  input  wire             pushValid,
  input  wire [WIDTH-1:0] pushCode,
  // Pop side
  input  wire             popReq,
  output wire [WIDTH-1:0] headCode,
  // State
  input  wire             flush,
  output wire             notEmpty
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    rdPtr_reg;
  reg [AW-1:0]    wrPtr_reg;
  reg [AW:0]      count_reg;

  localparam [AW:0] DEPTH_CNT = DEPTH;

  wire full      = (count_reg == DEPTH_CNT);
  wire doPop     = popReq && (count_reg != {(AW+1){1'b0}});
  // A full queue keeps its oldest errors and drops the new one.
  wire doPush    = pushValid && (!full || doPop);

  assign notEmpty = (count_reg != {(AW+1){1'b0}});
  assign headCode = mem_reg[rdPtr_reg];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
      localparam [AW-1:0] IDX = i;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_reg[i] <= {WIDTH{1'b0}};
        end else if (doPush && !flush && (wrPtr_reg == IDX)) begin
          mem_reg[i] <= pushCode;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdPtr_reg <= {AW{1'b0}};
      wrPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
      rdPtr_reg <= {AW{1'b0}};
      wrPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sss_error_queue

// ==== core/sss_status_summary.v ====
// Status summary byte, event latch, change latches and service requests.
`include "sss_consts.vh"

// Notes on behaviour
// - Error queue holds sixteen entries.
// - Event and change sources each give one masked summary bit.
// - Summary and masks readable; masks writable.
// - Serial link: request text on summary rise.
// - Serial poll returns summary byte; zero at power-on.
// - Control-P sends poll text then byte.
// - Bit 6 is OR of enabled summaries.
// - Bit 5 set by enabled event bits.
// - Bit 4 set while output data waits.
// - Bit 3 set while errors remain queued.
// - Bit 2 set by enabled change bits.
// - Master flag clears only when no enabled source is set.
// - Service request mask zero at power-up.
// - Mask one enables, zero masks.
// - Event word 16 bits, top byte zero.
// - Event word cleared at power-on and read.
// - Bad command sets bit 5, queues code.
// - Event mask one enables event bit.
// - Event bits hold until read or clear.
// - Event mask zero at power-on.
// - Event word bit positions as listed.
// - Reading event mask leaves it unchanged.
// - Reads answer a 16-bit binary value.
module sss_status_summary #(
  parameter ERR_WIDTH = 8,
  parameter ERR_DEPTH = 16,
  parameter ERR_AW    = 4,
  parameter ISC_WIDTH = 16
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 sys_rst,
  // Command port from the remote command parser
  input  wire                 cmdValid,
  input  wire [3:0]           cmdOp,
  input  wire [15:0]          cmdData,
  output reg                  rspValid,
  output reg  [15:0]          rspData,
  // Events from the instrument
  input  wire                 cmdErrPulse,
  input  wire [ERR_WIDTH-1:0] cmdErrCode,
  input  wire                 execErrPulse,
  input  wire                 devErrPulse,
  input  wire                 queryErrPulse,
  input  wire                 opDonePulse,
  input  wire                 powerCyclePulse,
  input  wire                 devClearPulse,
  input  wire                 msgWaiting,
  input  wire [ISC_WIDTH-1:0] iscFallPulse,
  input  wire [ISC_WIDTH-1:0] iscRisePulse,
  // Link
  input  wire                 linkSerial,
  input  wire                 serialPollReq,
  output reg                  serialPollValid,
  output reg  [7:0]           serialPollByte,
  input  wire                 rxCharValid,
  input  wire [7:0]           rxChar,
  output reg                  srqLine,
  output reg                  srqTextReq,
  output reg                  pollTextReq,
  input  wire                 pollTextDone,
  output reg                  pollByteValid,
  output reg  [7:0]           pollByteData
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_TEXT = 3'b010;
  localparam [2:0] ST_BYTE = 3'b100;

  reg [7:0]           sre_reg;
  reg [7:0]           esr_reg;
  reg [7:0]           ese_reg;
  reg [ISC_WIDTH-1:0] iscr0_reg;
  reg [ISC_WIDTH-1:0] iscr1_reg;
  reg [ISC_WIDTH-1:0] isce0_reg;
  reg [ISC_WIDTH-1:0] isce1_reg;
  reg [7:0]           stb_reg;
  reg                 mssPrev_reg;
  reg [2:0]           state_reg;
  reg [2:0]           state_next;

  reg [7:0]           esr_next;
  reg [ISC_WIDTH-1:0] iscr0_next;
  reg [ISC_WIDTH-1:0] iscr1_next;
  reg [7:0]           esrSet;
  reg [15:0]          rdValue;
  reg                 badOp;
  reg                 popErr;

  wire                event_summary_flag;
  wire                instrument_change_summary_flag;
  wire                error_waiting_flag;
  wire                master_summary_flag;
  wire [7:0]          stb_next;
  wire [ERR_WIDTH-1:0] errHead;
  wire                errPushValid;
  wire [ERR_WIDTH-1:0] errPushCode;
  wire                opValid;
  wire                clearAll;
  wire                ctrlP;

  assign opValid  = cmdValid;
  assign clearAll = devClearPulse ||
                    (opValid && ((cmdOp == `SSS_OP_CLS) || (cmdOp == `SSS_OP_RST)));
  assign ctrlP    = linkSerial && rxCharValid && (rxChar == `SSS_CHAR_CTRL_P);

  // Error queue.
  assign errPushValid = cmdErrPulse || badOp;
  assign errPushCode  = cmdErrPulse ? cmdErrCode : `SSS_ERR_BAD_CMD;

  sss_error_queue #(
    .WIDTH (ERR_WIDTH),
    .DEPTH (ERR_DEPTH),
    .AW    (ERR_AW)
  ) uErrQueue (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .pushValid (errPushValid),
    .pushCode  (errPushCode),
    .popReq    (popErr),
    .headCode  (errHead),
    .flush     (clearAll),
    .notEmpty  (error_waiting_flag)
  );

  // Summary bits, each gated by its own mask.
  assign event_summary_flag  = |(esr_reg & ese_reg);
  assign instrument_change_summary_flag = |(iscr0_reg & isce0_reg) | |(iscr1_reg & isce1_reg);
  // The master flag follows the masked OR directly, so it drops only once every enabled source is quiet.
  assign master_summary_flag  = ((event_summary_flag & sre_reg[`SSS_STB_ESB]) |
                 (msgWaiting & sre_reg[`SSS_STB_MAV]) |
                 (error_waiting_flag & sre_reg[`SSS_STB_EAV]) |
                 (instrument_change_summary_flag & sre_reg[`SSS_STB_INSTRUMENT_CHANGE_SUMMARY_FLAG]));

  assign stb_next = {1'b0, master_summary_flag, event_summary_flag, msgWaiting, error_waiting_flag, instrument_change_summary_flag, 2'b00};

  // Command decode.
  always @* begin
    badOp   = 1'b0;
    popErr  = 1'b0;
    rdValue = 16'h0000;
    if (opValid) begin
      case (cmdOp)
        `SSS_OP_RD_STB:   rdValue = {8'h00, stb_next};
        `SSS_OP_RD_SRE:   rdValue = {8'h00, sre_reg};
        `SSS_OP_RD_ESR:   rdValue = {8'h00, esr_reg};
        `SSS_OP_RD_ESE:   rdValue = {8'h00, ese_reg};
        `SSS_OP_RD_ISCR0: rdValue = iscr0_reg;
        `SSS_OP_RD_ISCR1: rdValue = iscr1_reg;
        `SSS_OP_RD_ISCE0: rdValue = isce0_reg;
        `SSS_OP_RD_ISCE1: rdValue = isce1_reg;
        `SSS_OP_RD_ERR: begin
          rdValue = error_waiting_flag ? {{(16-ERR_WIDTH){1'b0}}, errHead} : 16'h0000;
          popErr  = 1'b1;
        end
        `SSS_OP_WR_SRE, `SSS_OP_WR_ESE, `SSS_OP_WR_ISCE0, `SSS_OP_WR_ISCE1,
        `SSS_OP_CLS, `SSS_OP_RST: rdValue = 16'h0000;
        default:          badOp   = 1'b1;
      endcase
    end
  end

  // Event latch word; a new event in the clearing cycle still lands.
  always @* begin
    esrSet = 8'h00;
    esrSet[`SSS_ESR_PON] = powerCyclePulse;
    esrSet[`SSS_ESR_CME] = cmdErrPulse | badOp;
    esrSet[`SSS_ESR_EXE] = execErrPulse;
    esrSet[`SSS_ESR_DDE] = devErrPulse;
    esrSet[`SSS_ESR_QYE] = queryErrPulse;
    esrSet[`SSS_ESR_OPC] = opDonePulse;
    esr_next = esr_reg;
    if (clearAll || (opValid && (cmdOp == `SSS_OP_RD_ESR))) begin
      esr_next = 8'h00;
    end
    esr_next = (esr_next | esrSet) & `SSS_ESR_USED;
  end

  // Change latches clear on their own read and on clear status.
  always @* begin
    iscr0_next = iscr0_reg;
    iscr1_next = iscr1_reg;
    if (clearAll || (opValid && (cmdOp == `SSS_OP_RD_ISCR0))) begin
      iscr0_next = {ISC_WIDTH{1'b0}};
    end
    if (clearAll || (opValid && (cmdOp == `SSS_OP_RD_ISCR1))) begin
      iscr1_next = {ISC_WIDTH{1'b0}};
    end
    iscr0_next = iscr0_next | iscFallPulse;
    iscr1_next = iscr1_next | iscRisePulse;
  end

  // Registers.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sre_reg   <= `SSS_RST_SRE;
      esr_reg   <= `SSS_RST_ESR;
      ese_reg   <= `SSS_RST_ESE;
      iscr0_reg <= `SSS_RST_ISC;
      iscr1_reg <= `SSS_RST_ISC;
      isce0_reg <= `SSS_RST_ISC;
      isce1_reg <= `SSS_RST_ISC;
      stb_reg   <= `SSS_RST_STB;
    end else begin
      esr_reg   <= esr_next;
      iscr0_reg <= iscr0_next;
      iscr1_reg <= iscr1_next;
      stb_reg   <= stb_next;
      if (opValid && (cmdOp == `SSS_OP_WR_SRE)) begin
        sre_reg <= cmdData[7:0] & `SSS_STB_USED;
      end
      if (opValid && (cmdOp == `SSS_OP_WR_ESE)) begin
        ese_reg <= cmdData[7:0] & `SSS_ESR_USED;
      end
      if (opValid && (cmdOp == `SSS_OP_WR_ISCE0)) begin
        isce0_reg <= cmdData[ISC_WIDTH-1:0];
      end
      if (opValid && (cmdOp == `SSS_OP_WR_ISCE1)) begin
        isce1_reg <= cmdData[ISC_WIDTH-1:0];
      end
    end
  end

  // Query answers are binary; the formatter prints them in decimal.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
    end else begin
      rspValid <= 1'b0;
      if (opValid && !badOp) begin
        rspValid <= 1'b1;
        rspData  <= rdValue;
      end
    end
  end

  // Service request: a line on the parallel bus, text on serial links.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mssPrev_reg     <= 1'b0;
      srqLine         <= 1'b0;
      srqTextReq      <= 1'b0;
      serialPollValid <= 1'b0;
      serialPollByte  <= 8'h00;
    end else begin
      mssPrev_reg     <= master_summary_flag;
      srqLine         <= master_summary_flag && !linkSerial;
      srqTextReq      <= master_summary_flag && !mssPrev_reg && linkSerial;
      serialPollValid <= serialPollReq;
      if (serialPollReq) begin
        serialPollByte <= stb_reg;
      end
    end
  end

  // Control-P: poll reply text first, then the summary byte.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctrlP) begin
          state_next = ST_TEXT;
        end
      end
      ST_TEXT: begin
        if (pollTextDone) begin
          state_next = ST_BYTE;
        end
      end
      ST_BYTE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      pollTextReq   <= 1'b0;
      pollByteValid <= 1'b0;
      pollByteData  <= 8'h00;
    end else begin
      state_reg     <= state_next;
      pollTextReq   <= (state_reg == ST_IDLE) && ctrlP;
      pollByteValid <= 1'b0;
      // Sampled when the byte leaves so it shows the state after the text.
      if (state_reg == ST_BYTE) begin
        pollByteValid <= 1'b1;
        pollByteData  <= stb_reg;
      end
    end
  end

endmodule // sss_status_summary

// ==== test/sss_status_summary_chk.sv ====
// Port checker for the status summary block.
`include "sss_consts.vh"
module sss_status_summary_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        sys_rst,
  // Command port
  input wire        cmdValid,
  input wire [3:0]  cmdOp,
  input wire        rspValid,
  input wire [15:0] rspData,
  // Link side
  input wire        linkSerial,
  input wire        serialPollReq,
  input wire        serialPollValid,
  input wire [7:0]  serialPollByte,
  input wire        srqLine,
  input wire        srqTextReq,
  input wire        pollTextDone,
  input wire        pollByteValid,
  input wire [7:0]  pollByteData
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_known_op_answered: assert property (cmdValid && cmdOp != 4'hf |=> rspValid)
    else $error("known op not answered");
  chk_bad_op_silent: assert property (cmdValid && cmdOp == 4'hf |=> !rspValid)
    else $error("bad op answered");
  chk_poll_answer: assert property (serialPollReq |=> serialPollValid)
    else $error("serial poll not answered");
  chk_serial_no_line: assert property (linkSerial && $past(linkSerial) |-> !srqLine)
    else $error("request line driven on serial link");
  chk_text_one_pulse: assert property (srqTextReq |=> !srqTextReq)
    else $error("request text pulse too long");
  chk_byte_after_text: assert property (pollTextDone |-> ##2 pollByteValid)
    else $error("poll byte not sent after text");
  chk_poll_unused_zero: assert property (serialPollValid |-> (serialPollByte & ~`SSS_STB_USED) == 8'h00)
    else $error("unused poll bits set");
  chk_reply_unused_zero: assert property (pollByteValid |-> (pollByteData & ~`SSS_STB_USED) == 8'h00)
    else $error("unused reply bits set");
  chk_short_upper_zero: assert property (rspValid && $past(cmdOp) <= 4'h5 |-> rspData[15:8] == 8'h00)
    else $error("upper answer byte not zero");
endmodule // sss_status_summary_chk

bind sss_status_summary sss_status_summary_chk chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .rspValid(rspValid),
  .rspData(rspData), .linkSerial(linkSerial), .serialPollReq(serialPollReq),
  .serialPollValid(serialPollValid), .serialPollByte(serialPollByte), .srqLine(srqLine),
  .srqTextReq(srqTextReq), .pollTextDone(pollTextDone), .pollByteValid(pollByteValid),
  .pollByteData(pollByteData));

// ==== test/sss_text_sender.sv ====
// Model of the serial text sender that sends the poll reply text.
module sss_text_sender #(
  parameter DELAY = 3
) (
  // Clock and reset
  input wire  ref_clk,
  input wire  sys_rst,
  // Handshake
  input wire  pollTextReq,
  output reg  pollTextDone
);
  timeunit 1ns;
  timeprecision 1ns;
  integer left;
  // Text takes several cycles so the byte must really wait for it.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 0;
      pollTextDone <= 1'b0;
    end else begin
      pollTextDone <= (left == 1);
      if (pollTextReq) left <= DELAY;
      else if (left > 0) left <= left - 1;
    end
  end
endmodule // sss_text_sender

// ==== test/test_status_summary_reporting.sv ====
// Self-checking testbench for the status summary block.
`include "sss_consts.vh"
module test_status_summary_reporting;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, sys_rst = 1, cmdValid = 0, msgWaiting = 0, linkSerial = 0;
  logic [3:0]  cmdOp = 0;
  logic [15:0] cmdData = 0, rise = 0;
  logic [7:0]  code = 0;
  logic [8:0]  evp = 0;
  wire         rspValid, serialPollValid, srqLine, srqTextReq, pollTextReq, pollTextDone, pollByteValid;
  wire  [15:0] rspData;
  wire  [7:0]  serialPollByte, pollByteData;
  integer      failures = 0, comparisons = 0, srqCnt = 0, k;
  sss_status_summary uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData), .cmdErrPulse(evp[0]), .cmdErrCode(code),
    .execErrPulse(evp[1]), .devErrPulse(evp[2]), .queryErrPulse(evp[3]), .opDonePulse(evp[4]),
    .powerCyclePulse(evp[5]), .devClearPulse(evp[6]), .msgWaiting(msgWaiting), .iscFallPulse(16'h0000),
    .iscRisePulse(rise), .linkSerial(linkSerial), .serialPollReq(evp[7]), .serialPollValid(serialPollValid),
    .serialPollByte(serialPollByte), .rxCharValid(evp[8]), .rxChar(8'h10), .srqLine(srqLine),
    .srqTextReq(srqTextReq), .pollTextReq(pollTextReq), .pollTextDone(pollTextDone),
    .pollByteValid(pollByteValid), .pollByteData(pollByteData));
  sss_text_sender #(.DELAY(3)) far (.ref_clk(ref_clk), .sys_rst(sys_rst), .pollTextReq(pollTextReq),
    .pollTextDone(pollTextDone));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (srqTextReq === 1'b1) srqCnt <= srqCnt + 1;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command; the answer strobe is looked at in its single cycle.
  task automatic cmd(input logic [3:0] op, input logic [15:0] d, input logic [15:0] exp);
    @(posedge ref_clk);
    cmdValid <= 1; cmdOp <= op; cmdData <= d;
    @(posedge ref_clk);
    cmdValid <= 0;
    #1;
    chk({15'h0, rspValid}, {15'h0, op != 4'hf});
    if (op != 4'hf) chk(rspData, exp);
  endtask
  task automatic pulse(input logic [8:0] v, input logic [7:0] c, input logic [15:0] r);
    @(posedge ref_clk);
    evp <= v; code <= c; rise <= r;
    @(posedge ref_clk);
    evp <= 0; rise <= 0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 0;
    cmd(`SSS_OP_RD_STB, 0, 0);
    cmd(`SSS_OP_RD_SRE, 0, 0);
    cmd(`SSS_OP_RD_ESR, 0, 0);
    cmd(`SSS_OP_RD_ESE, 0, 0);
    $display("reset values done");
    cmd(`SSS_OP_WR_SRE, 16'h00ff, 0);
    cmd(`SSS_OP_RD_SRE, 0, 16'h007c);
    cmd(`SSS_OP_WR_ESE, 16'h00bd, 0);
    repeat (2) cmd(`SSS_OP_RD_ESE, 0, 16'h00bd);
    pulse(9'h03e, 0, 0);
    cmd(`SSS_OP_RD_STB, 0, 16'h0060);
    chk({15'h0, srqLine}, 1);
    cmd(`SSS_OP_RD_ESR, 0, 16'h009d);
    cmd(`SSS_OP_RD_ESR, 0, 0);
    cmd(`SSS_OP_RD_STB, 0, 0);
    pulse(9'h001, 8'h42, 0);
    cmd(`SSS_OP_RD_STB, 0, 16'h0068);
    cmd(`SSS_OP_RD_ERR, 0, 16'h0042);
    pulse(9'h040, 0, 0);
    cmd(`SSS_OP_RD_STB, 0, 0);
    cmd(4'hf, 0, 0);
    cmd(`SSS_OP_RD_ESR, 0, 16'h0020);
    cmd(`SSS_OP_RD_ERR, 0, 16'h0001);
    $display("events done");
    for (k = 1; k <= 17; k++) pulse(9'h001, k[7:0], 0);
    for (k = 1; k <= 17; k++) cmd(`SSS_OP_RD_ERR, 0, (k < 17) ? k[15:0] : 16'h0);
    cmd(`SSS_OP_CLS, 0, 0);
    $display("error queue done");
    msgWaiting <= 1;
    cmd(`SSS_OP_WR_SRE, 16'h0020, 0);
    cmd(`SSS_OP_RD_STB, 0, 16'h0010);
    cmd(`SSS_OP_WR_SRE, 16'h0010, 0);
    cmd(`SSS_OP_RD_STB, 0, 16'h0050);
    msgWaiting <= 0;
    cmd(`SSS_OP_WR_SRE, 16'h0004, 0);
    cmd(`SSS_OP_WR_ISCE1, 16'h8001, 0);
    cmd(`SSS_OP_RD_ISCE1, 0, 16'h8001);
    pulse(0, 0, 16'h8000);
    cmd(`SSS_OP_RD_STB, 0, 16'h0044);
    cmd(`SSS_OP_RD_ISCR1, 0, 16'h8000);
    cmd(`SSS_OP_CLS, 0, 0);
    cmd(`SSS_OP_RD_STB, 0, 0);
    $display("masks and changes done");
    linkSerial <= 1;
    cmd(`SSS_OP_WR_SRE, 16'h0020, 0);
    cmd(`SSS_OP_WR_ESE, 16'h0001, 0);
    pulse(9'h010, 0, 0);
    pulse(9'h080, 0, 0);
    chk(serialPollByte, 16'h0060);
    chk(srqCnt, 1);
    pulse(9'h100, 0, 0);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (pollByteValid !== 1'b1 && k < 50);
    chk({15'h0, pollByteValid}, 1);
    chk(pollByteData, 16'h0060);
    cmd(`SSS_OP_RD_ESR, 0, 16'h0001);
    pulse(9'h010, 0, 0);
    cmd(`SSS_OP_RD_STB, 0, 16'h0060);
    chk(srqCnt, 2);
    $display("serial link done");
    report_and_stop();
  end
  // The whole run is well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
endmodule // test_status_summary_reporting
